// *** rtl/thermal_cfg_pkg.sv ***
// constants and helpers shared by the thermal event configuration logic
// How it works
// RULE1 - bit 0 picks comparator or latched interrupt
// RULE2 - bit 1 picks event output active level
// RULE3 - bit 2 limits events to critical only
// RULE4 - bit 3 gates the event output
// RULE5 - locks freeze bits 0 to 3
// RULE6 - bit 4 reads current event drive
// RULE7 - only window or critical trips raise events
// RULE8 - writing bit 4 changes nothing
// RULE9 - bit 5 clears latched interrupt event
// RULE10 - clear does nothing in comparator mode
// RULE11 - clear bit always reads zero
// RULE12 - no clear while above critical limit
// RULE13 - alarm lock blocks window limit writes
// RULE14 - critical lock blocks critical limit writes
// RULE15 - locks stick until power-on reset
// RULE16 - one write sets a lock
// RULE17 - shutdown stops sensing and all events
// RULE18 - locks block entering shutdown, not leaving
// RULE19 - bits 10 to 9 pick hysteresis
// RULE20 - power-on leaves configuration all zero
// RULE21 - events follow window and critical trips
// RULE22 - trip flags ignore configuration bits; here shutdown (bit 8) stops sampling and bits 10 to 9 set hysteresis
// RULE23 - reserved bits read zero, ignore writes
// RULE24 - host disables events while changing limits
package thermal_cfg_pkg;

  // configuration field positions
  localparam int MODE_BIT = 0;
  localparam int POLARITY_BIT = 1;
  localparam int CRIT_ONLY_BIT = 2;
  localparam int ENABLE_BIT = 3;
  localparam int STATUS_BIT = 4;
  localparam int CLEAR_BIT = 5;
  localparam int ALARM_LOCK_BIT = 6;
  localparam int CRIT_LOCK_BIT = 7;
  localparam int SHUTDOWN_BIT = 8;
  localparam int HYST_LSB = 9;
  localparam int HYST_MSB = 10;

  // reset values
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [15:0] TRIP_RESET = 16'h0000;

  // limit registers keep sign and value bits only
  localparam logic [15:0] TRIP_MASK = 16'h1FFC;

  // hysteresis in sample units of 0.0625 degrees
  localparam logic [7:0] HYST_NONE_CNT = 8'h00;
  localparam logic [7:0] HYST_1P5_CNT = 8'h18;
  localparam logic [7:0] HYST_3_CNT = 8'h30;
  localparam logic [7:0] HYST_6_CNT = 8'h60;

  function automatic logic [7:0] hyst_counts(input logic [1:0] code);
    logic [7:0] cnt;
    case (code)
      2'h1: cnt = HYST_1P5_CNT;
      2'h2: cnt = HYST_3_CNT;
      2'h3: cnt = HYST_6_CNT;
      default: cnt = HYST_NONE_CNT;
    endcase
    return cnt;
  endfunction

endpackage

// *** rtl/trip_compare.sv ***
// one temperature limit comparator with hysteresis
`timescale 1ns/100ps
module trip_compare #(
  parameter bit TRIP_ABOVE = 1'b1,
  parameter bit INCLUSIVE = 1'b0
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // sample and limit
  input wire logic sampleValid,
  input wire logic [12:0] sample,
  input wire logic [12:0] limit,
  input wire logic [7:0] hyst,
  // result
  output logic tripped
);

  typedef struct packed {
    logic tripped;
  } cmp_state_type;

  cmp_state_type state_r;
  cmp_state_type state_nxt;
  logic signed [14:0] sampleExt;
  logic signed [14:0] limitExt;
  logic signed [14:0] hystExt;
  logic signed [14:0] thresh;

  always_comb
  begin
    state_nxt = state_r;
    sampleExt = {{2{sample[12]}}, sample};
    limitExt = {{2{limit[12]}}, limit};
    hystExt = {7'h00, hyst};
    // once tripped, release point moves back by the hysteresis
    if (TRIP_ABOVE)
    begin
      thresh = state_r.tripped ? limitExt - hystExt : limitExt;
    end
    else
    begin
      thresh = state_r.tripped ? limitExt + hystExt : limitExt;
    end
    if (sampleValid)
    begin
      if (TRIP_ABOVE)
      begin
        state_nxt.tripped = INCLUSIVE ? (sampleExt >= thresh) : (sampleExt > thresh);
      end
      else
      begin
        state_nxt.tripped = sampleExt < thresh;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign tripped = state_r.tripped;

endmodule

// *** rtl/event_pin_drive.sv ***
// open-drain event pin with selectable active level
`timescale 1ns/100ps
module event_pin_drive (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // event request
  input wire logic assertNxt,
  input wire logic activeHighNxt,
  // pin
  output logic pinOut,
  output logic pinOe
);

  typedef struct packed {
    logic pinOut;
    logic pinOe;
  } pin_state_type;

  pin_state_type state_r;
  pin_state_type state_nxt;

  always_comb
  begin
    state_nxt.pinOut = 1'b0;
    // active high releases the line to the pull-up
    state_nxt.pinOe = activeHighNxt ? !assertNxt : assertNxt; // RULE2
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign pinOut = state_r.pinOut;
  assign pinOe = state_r.pinOe;

endmodule

// *** rtl/thermal_event_config_logic.sv ***
// configuration register, limit locks and event control of the temperature monitor
`timescale 1ns/100ps
module thermal_event_config_logic (
  // clock and power-on reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // configuration register write
  input wire logic cfgWrite,
  input wire logic [15:0] cfgWrData,
  // limit register writes
  input wire logic alarmUpperWrite,
  input wire logic alarmLowerWrite,
  input wire logic critWrite,
  input wire logic [15:0] tripWrData,
  // converter samples
  input wire logic tempValid,
  input wire logic [12:0] tempSample,
  // register read values
  output logic [15:0] cfgReadData,
  output logic [15:0] alarmUpper,
  output logic [15:0] alarmLower,
  output logic [15:0] critLimit,
  // trip status
  output logic aboveCrit,
  output logic aboveAlarm,
  output logic belowAlarm,
  // sensor control
  output logic sensorEnable,
  // event pin
  output logic eventPinOut,
  output logic eventPinOe
);

  ////////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic intMode;
    logic polarity;
    logic critOnly;
    logic enable;
    logic alarmLock;
    logic critLock;
    logic shutdown;
    logic [1:0] hyst;
    logic pending;
    logic causePrev;
    logic sensorOn;
    logic [15:0] cfgRead;
    logic [15:0] alarmUpper;
    logic [15:0] alarmLower;
    logic [15:0] critLimit;
  } ctrl_state_type;

  ctrl_state_type state_r;
  ctrl_state_type state_nxt;
  logic locked;
  logic cause;
  logic clearReq;
  logic assertNxt;
  logic [7:0] hystCnt;
  logic sampleTake;
  logic critTrip;
  logic upperTrip;
  logic lowerTrip;

  ////////////////////////////////////////////////////////////////////////////////
  // trip detection, free of configuration gating except shutdown, which stops sampling

  assign hystCnt = thermal_cfg_pkg::hyst_counts(state_r.hyst); // RULE19
  assign sampleTake = tempValid && state_r.sensorOn; // RULE17

  trip_compare #(
    .TRIP_ABOVE(1'b1),
    .INCLUSIVE(1'b1)
  ) critCmp (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .sampleValid(sampleTake),
    .sample(tempSample),
    .limit(state_r.critLimit[12:0]),
    .hyst(hystCnt),
    .tripped(critTrip)
  ); // RULE22

  trip_compare #(
    .TRIP_ABOVE(1'b1),
    .INCLUSIVE(1'b0)
  ) upperCmp (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .sampleValid(sampleTake),
    .sample(tempSample),
    .limit(state_r.alarmUpper[12:0]),
    .hyst(hystCnt),
    .tripped(upperTrip)
  ); // RULE22

  trip_compare #(
    .TRIP_ABOVE(1'b0),
    .INCLUSIVE(1'b0)
  ) lowerCmp (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .sampleValid(sampleTake),
    .sample(tempSample),
    .limit(state_r.alarmLower[12:0]),
    .hyst(hystCnt),
    .tripped(lowerTrip)
  ); // RULE22

  ////////////////////////////////////////////////////////////////////////////////
  // configuration and event control

  always_comb
  begin
    state_nxt = state_r;
    locked = state_r.alarmLock || state_r.critLock;
    clearReq = cfgWrite && cfgWrData[thermal_cfg_pkg::CLEAR_BIT];
    // event cause from trips only
    cause = state_r.critOnly ? critTrip : (critTrip || upperTrip || lowerTrip); // RULE3 RULE7 RULE21

    if (cfgWrite)
    begin
      // mode bits frozen by either lock
      if (!locked) // RULE5
      begin
        state_nxt.intMode = cfgWrData[thermal_cfg_pkg::MODE_BIT]; // RULE1
        state_nxt.polarity = cfgWrData[thermal_cfg_pkg::POLARITY_BIT]; // RULE2
        state_nxt.critOnly = cfgWrData[thermal_cfg_pkg::CRIT_ONLY_BIT]; // RULE3
        state_nxt.enable = cfgWrData[thermal_cfg_pkg::ENABLE_BIT]; // RULE4
      end
      // locks only ever set
      state_nxt.alarmLock = state_r.alarmLock || cfgWrData[thermal_cfg_pkg::ALARM_LOCK_BIT]; // RULE15 RULE16
      state_nxt.critLock = state_r.critLock || cfgWrData[thermal_cfg_pkg::CRIT_LOCK_BIT]; // RULE15 RULE16
      // leaving shutdown always allowed, entering only unlocked
      if (!cfgWrData[thermal_cfg_pkg::SHUTDOWN_BIT] || !locked) // RULE18
      begin
        state_nxt.shutdown = cfgWrData[thermal_cfg_pkg::SHUTDOWN_BIT]; // RULE17
      end
      state_nxt.hyst = cfgWrData[thermal_cfg_pkg::HYST_MSB:thermal_cfg_pkg::HYST_LSB]; // RULE19
    end

    // limit writes, reserved bits dropped
    if (alarmUpperWrite && !state_r.alarmLock) // RULE13
    begin
      state_nxt.alarmUpper = tripWrData & thermal_cfg_pkg::TRIP_MASK;
    end
    if (alarmLowerWrite && !state_r.alarmLock) // RULE13
    begin
      state_nxt.alarmLower = tripWrData & thermal_cfg_pkg::TRIP_MASK;
    end
    if (critWrite && !state_r.critLock) // RULE14
    begin
      state_nxt.critLimit = tripWrData & thermal_cfg_pkg::TRIP_MASK;
    end

    // event latch
    state_nxt.causePrev = cause;
    if (state_r.shutdown) // RULE17
    begin
      state_nxt.pending = 1'b0;
    end
    else if (state_r.intMode)
    begin
      // new trip sets; clear refused above critical; set wins over clear
      state_nxt.pending = (cause && !state_r.causePrev)
        || (state_r.pending && !(clearReq && !critTrip)); // RULE9 RULE12
    end
    else
    begin
      state_nxt.pending = cause; // RULE10
    end

    assertNxt = state_nxt.pending && state_nxt.enable && !state_nxt.shutdown; // RULE4 RULE17
    state_nxt.sensorOn = !state_nxt.shutdown; // RULE17

    // read image: status live, clear and reserved read zero
    state_nxt.cfgRead = thermal_cfg_pkg::CFG_RESET;
    state_nxt.cfgRead[thermal_cfg_pkg::MODE_BIT] = state_nxt.intMode;
    state_nxt.cfgRead[thermal_cfg_pkg::POLARITY_BIT] = state_nxt.polarity;
    state_nxt.cfgRead[thermal_cfg_pkg::CRIT_ONLY_BIT] = state_nxt.critOnly;
    state_nxt.cfgRead[thermal_cfg_pkg::ENABLE_BIT] = state_nxt.enable;
    state_nxt.cfgRead[thermal_cfg_pkg::STATUS_BIT] = assertNxt; // RULE6 RULE8
    state_nxt.cfgRead[thermal_cfg_pkg::CLEAR_BIT] = 1'b0; // RULE11
    state_nxt.cfgRead[thermal_cfg_pkg::ALARM_LOCK_BIT] = state_nxt.alarmLock;
    state_nxt.cfgRead[thermal_cfg_pkg::CRIT_LOCK_BIT] = state_nxt.critLock;
    state_nxt.cfgRead[thermal_cfg_pkg::SHUTDOWN_BIT] = state_nxt.shutdown;
    state_nxt.cfgRead[thermal_cfg_pkg::HYST_MSB:thermal_cfg_pkg::HYST_LSB] = state_nxt.hyst; // RULE23
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state_r <= '0; // RULE20
      state_r.sensorOn <= 1'b1;
      state_r.cfgRead <= thermal_cfg_pkg::CFG_RESET;
      state_r.alarmUpper <= thermal_cfg_pkg::TRIP_RESET;
      state_r.alarmLower <= thermal_cfg_pkg::TRIP_RESET;
      state_r.critLimit <= thermal_cfg_pkg::TRIP_RESET;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin and outputs

  event_pin_drive pinDrive (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .assertNxt(assertNxt),
    .activeHighNxt(state_nxt.polarity),
    .pinOut(eventPinOut),
    .pinOe(eventPinOe)
  ); // RULE6

  assign cfgReadData = state_r.cfgRead;
  assign alarmUpper = state_r.alarmUpper;
  assign alarmLower = state_r.alarmLower;
  assign critLimit = state_r.critLimit;
  assign aboveCrit = critTrip;
  assign aboveAlarm = upperTrip;
  assign belowAlarm = lowerTrip;
  assign sensorEnable = state_r.sensorOn;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  a_mode_bits_frozen: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE5
    (state_r.alarmLock || state_r.critLock) && cfgWrite |=> $stable(cfgReadData[3:0]))
    else $error("mode bits changed while locked");

  a_lock_stays_set: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE15
    (cfgReadData[6] || cfgReadData[7]) |=> cfgReadData[7:6] == ($past(cfgReadData[7:6]) | cfgReadData[7:6]))
    else $error("lock bit cleared by a write");

  a_lock_one_write: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE16
    cfgWrite && cfgWrData[7] |=> cfgReadData[7] && state_r.critLock)
    else $error("lock not set by single write");

  a_alarm_write_blocked: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE13
    state_r.alarmLock |=> $stable(alarmUpper) && $stable(alarmLower))
    else $error("alarm limit changed while locked");

  a_crit_write_blocked: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE14
    state_r.critLock |=> $stable(critLimit))
    else $error("critical limit changed while locked");

  a_clear_reads_zero: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE11
    cfgReadData[5] == 1'b0 && cfgReadData[15:11] == 5'h00)
    else $error("write-only or reserved bit reads one");

  a_crit_holds_event: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE12
    state_r.pending && critTrip && !state_r.shutdown && state_r.intMode && clearReq |=> state_r.pending)
    else $error("event cleared above critical limit");

  a_comparator_follows: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE10
    !state_r.intMode && !state_r.shutdown |=> state_r.pending == $past(cause))
    else $error("comparator event does not follow trips");

  a_shutdown_silent: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE17
    state_r.shutdown |-> !cfgReadData[4] && !sensorEnable)
    else $error("event or sensing during shutdown");

  a_shutdown_entry_blocked: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE18
    (state_r.alarmLock || state_r.critLock) && !state_r.shutdown && cfgWrite ##1 1'b1 |-> !state_r.shutdown)
    else $error("shutdown entered while locked");

  a_status_matches_pin: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE6
    cfgReadData[4] == (cfgReadData[1] ? !eventPinOe : eventPinOe))
    else $error("status bit disagrees with pin drive");

  a_disabled_output_idle: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE4
    !cfgReadData[3] |-> !cfgReadData[4])
    else $error("event driven while output disabled");

  a_mode_write_taken: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE1
    !(state_r.alarmLock || state_r.critLock) && cfgWrite |=> cfgReadData[0] == $past(cfgWrData[0]))
    else $error("event mode write not taken");

  a_polarity_write_taken: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE2
    !(state_r.alarmLock || state_r.critLock) && cfgWrite |=> cfgReadData[1] == $past(cfgWrData[1]))
    else $error("polarity write not taken");

  a_crit_only_taken: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE3
    !(state_r.alarmLock || state_r.critLock) && cfgWrite |=> cfgReadData[2] == $past(cfgWrData[2]))
    else $error("critical-only write not taken");

  a_enable_write_taken: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE4
    !(state_r.alarmLock || state_r.critLock) && cfgWrite |=> cfgReadData[3] == $past(cfgWrData[3]))
    else $error("output enable write not taken");

  a_crit_only_cause: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE3
    state_r.critOnly && !state_r.intMode && !state_r.shutdown |=> state_r.pending == $past(critTrip))
    else $error("critical-only event follows other trips");

  a_event_needs_trip: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE7
    !state_r.pending && !cause |=> !state_r.pending)
    else $error("event raised without a trip");

  a_status_write_ignored: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE8
    !(state_r.alarmLock || state_r.critLock) && cfgWrite && cfgWrData[4] && !cfgWrData[3] |=> !cfgReadData[4])
    else $error("status bit set by a write");

  a_clear_comparator_none: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE10
    !state_r.intMode && !state_r.shutdown && clearReq && cause |=> state_r.pending)
    else $error("clear acted in comparator mode");

  a_clear_drops_event: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE9
    state_r.intMode && clearReq && !critTrip && !(cause && !state_r.causePrev) |=> !state_r.pending)
    else $error("latched event not cleared");

  a_clear_zero_keeps: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE9
    state_r.intMode && !state_r.shutdown && state_r.pending && !clearReq |=> state_r.pending)
    else $error("latched event lost without a clear");

  a_int_latch_set: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE1
    state_r.intMode && !state_r.shutdown && cause && !state_r.causePrev |=> state_r.pending)
    else $error("interrupt event not latched");

  a_sample_refused_off: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE17
    !sensorEnable && tempValid |=> $stable(aboveCrit) && $stable(aboveAlarm) && $stable(belowAlarm))
    else $error("sample taken during shutdown");

  a_shutdown_leave_ok: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE18
    cfgWrite && !cfgWrData[8] |=> !cfgReadData[8] && sensorEnable)
    else $error("shutdown exit refused");

  a_hyst_field_taken: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE19
    cfgWrite |=> cfgReadData[10:9] == $past(cfgWrData[10:9]))
    else $error("hysteresis write not taken");

  a_alarm_write_taken: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE13
    alarmUpperWrite && !state_r.alarmLock |=> alarmUpper == ($past(tripWrData) & thermal_cfg_pkg::TRIP_MASK))
    else $error("unlocked upper limit write not taken");

  a_crit_write_taken: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE14
    critWrite && !state_r.critLock |=> critLimit == ($past(tripWrData) & thermal_cfg_pkg::TRIP_MASK))
    else $error("unlocked critical limit write not taken");

  a_trips_hold_idle: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE22
    !tempValid |=> $stable(aboveCrit) && $stable(aboveAlarm) && $stable(belowAlarm))
    else $error("trip flag moved without a sample");

  a_window_raises_event: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE21
    !state_r.critOnly && !state_r.intMode && !state_r.shutdown && upperTrip |=> state_r.pending)
    else $error("window trip raised no event");

  a_shutdown_pin_idle: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE17
    state_r.shutdown |-> eventPinOe == cfgReadData[1])
    else $error("event pin driven during shutdown");

endmodule

// *** dv/mgmt_host_model.sv ***
// bus host model driving configuration, limit and sample strobes
`timescale 1ns/100ps
module mgmt_host_model (
  // clock
  input wire logic clk_sys,
  // configuration write
  output logic cfgWrite,
  output logic [15:0] cfgWrData,
  // limit writes
  output logic alarmUpperWrite,
  output logic alarmLowerWrite,
  output logic critWrite,
  output logic [15:0] tripWrData,
  // converter samples
  output logic tempValid,
  output logic [12:0] tempSample
);
  initial
  begin
    cfgWrite = 1'b0;
    cfgWrData = 16'h0000;
    alarmUpperWrite = 1'b0;
    alarmLowerWrite = 1'b0;
    critWrite = 1'b0;
    tripWrData = 16'h0000;
    tempValid = 1'b0;
    tempSample = 13'h0000;
  end

  ////////////////////////////////////////////////////////////
  // released data shows the inverse, never a stale value
  task automatic write_cfg(input logic [15:0] d);
    @(posedge clk_sys);
    cfgWrite <= 1'b1;
    cfgWrData <= d;
    @(posedge clk_sys);
    cfgWrite <= 1'b0;
    cfgWrData <= ~d;
  endtask

  // sel 0 upper, 1 lower, 2 critical
  task automatic write_limit(input logic [1:0] sel, input logic [15:0] d);
    @(posedge clk_sys);
    alarmUpperWrite <= (sel == 2'h0);
    alarmLowerWrite <= (sel == 2'h1);
    critWrite <= (sel == 2'h2);
    tripWrData <= d;
    @(posedge clk_sys);
    alarmUpperWrite <= 1'b0;
    alarmLowerWrite <= 1'b0;
    critWrite <= 1'b0;
    tripWrData <= ~d;
  endtask

  task automatic give_sample(input logic [12:0] t);
    @(posedge clk_sys);
    tempValid <= 1'b1;
    tempSample <= t;
    @(posedge clk_sys);
    tempValid <= 1'b0;
    tempSample <= ~t;
  endtask
endmodule

// *** dv/thermal_event_config_logic_tb_top.sv ***
// testbench of the thermal event configuration logic
`timescale 1ns/100ps
`define CHK(g, e) chk(32'(g), 32'(e))
module thermal_event_config_logic_tb_top;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic cfgWrite, alarmUpperWrite, alarmLowerWrite, critWrite, tempValid;
  logic [15:0] cfgWrData, tripWrData, cfgReadData, alarmUpper, alarmLower, critLimit;
  logic [12:0] tempSample;
  logic aboveCrit, aboveAlarm, belowAlarm, sensorEnable, eventPinOut, eventPinOe;
  wire eventLine;
  int errors = 0;
  int checked = 0;
  int cycles = 0;

  always #20 clk_sys = ~clk_sys;
  // pulled-up open-drain event line
  assign eventLine = (eventPinOe === 1'b1) ? eventPinOut : 1'b1;

  mgmt_host_model host (.clk_sys(clk_sys), .cfgWrite(cfgWrite), .cfgWrData(cfgWrData),
    .alarmUpperWrite(alarmUpperWrite), .alarmLowerWrite(alarmLowerWrite), .critWrite(critWrite),
    .tripWrData(tripWrData), .tempValid(tempValid), .tempSample(tempSample));

  thermal_event_config_logic DUT (.clk_sys(clk_sys), .rst_n(rst_n), .cfgWrite(cfgWrite),
    .cfgWrData(cfgWrData), .alarmUpperWrite(alarmUpperWrite), .alarmLowerWrite(alarmLowerWrite),
    .critWrite(critWrite), .tripWrData(tripWrData), .tempValid(tempValid), .tempSample(tempSample),
    .cfgReadData(cfgReadData), .alarmUpper(alarmUpper), .alarmLower(alarmLower), .critLimit(critLimit),
    .aboveCrit(aboveCrit), .aboveAlarm(aboveAlarm), .belowAlarm(belowAlarm),
    .sensorEnable(sensorEnable), .eventPinOut(eventPinOut), .eventPinOe(eventPinOe));

  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  // status and pin register on the same edge as the write; wait two more cycles to settle
  task automatic wcfg(input logic [15:0] d);
    host.write_cfg(d);
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  task automatic lim(input logic [1:0] sel, input logic [15:0] d);
    host.write_limit(sel, d);
    #1;
  endtask

  task automatic smp(input logic [12:0] t);
    host.give_sample(t);
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      errors++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    `CHK(cfgReadData, 16'h0000);
    `CHK({critLimit, sensorEnable, eventPinOe}, 18'h0_0002);
    wcfg(16'hF830);
    `CHK(cfgReadData, 16'h0000);
    for (int i = 0; i < 4; i++)
    begin
      wcfg({5'h00, i[1:0], 9'h007});
      `CHK(cfgReadData, {5'h00, i[1:0], 9'h007});
    end
    wcfg(16'h0000);
    done("fields");
    lim(2'h2, 16'hFFFF);
    `CHK(critLimit, 16'h1FFC);
    lim(2'h2, 16'h0500);
    lim(2'h0, 16'h0400);
    wcfg(16'h0008);
    smp(13'h0600);
    `CHK(aboveCrit, 1'b1);
    `CHK(cfgReadData, 16'h0018);
    `CHK({eventLine, eventPinOe}, 2'h1);
    wcfg(16'h0028);
    `CHK(cfgReadData, 16'h0018);
    wcfg(16'h000A);
    `CHK({cfgReadData, eventPinOe}, 17'h0_0034);
    wcfg(16'h0008);
    smp(13'h0100);
    `CHK({cfgReadData, aboveCrit, eventLine}, 18'h0_0021);
    smp(13'h0450);
    `CHK({cfgReadData, aboveAlarm}, 17'h0_0031);
    wcfg(16'h000C);
    `CHK(cfgReadData, 16'h000C);
    wcfg(16'h0000);
    `CHK({cfgReadData, eventPinOe, aboveAlarm}, 18'h0_0001);
    smp(13'h1F00);
    `CHK({aboveAlarm, belowAlarm}, 2'h1);
    done("comparator");
    smp(13'h0100);
    wcfg(16'h0009);
    smp(13'h0450);
    `CHK(cfgReadData, 16'h0019);
    smp(13'h0100);
    `CHK(cfgReadData, 16'h0019);
    wcfg(16'h0029);
    `CHK(cfgReadData, 16'h0009);
    smp(13'h0600);
    wcfg(16'h0029);
    `CHK(cfgReadData, 16'h0019);
    smp(13'h0100);
    wcfg(16'h0029);
    `CHK(cfgReadData, 16'h0009);
    done("interrupt");
    wcfg(16'h0208);
    smp(13'h0600);
    smp(13'h04F0);
    `CHK(aboveCrit, 1'b1);
    smp(13'h04E0);
    `CHK(aboveCrit, 1'b0);
    wcfg(16'h0108);
    `CHK({cfgReadData, sensorEnable, eventPinOe}, 18'h0_0420);
    smp(13'h0600);
    `CHK(aboveCrit, 1'b0);
    done("shutdown");
    wcfg(16'h0148);
    `CHK(cfgReadData, 16'h0148);
    wcfg(16'h0008);
    smp(13'h0100);
    `CHK({cfgReadData, sensorEnable}, 17'h0_0091);
    wcfg(16'h0107);
    `CHK({cfgReadData, sensorEnable}, 17'h0_0091);
    lim(2'h0, 16'h0700);
    `CHK(alarmUpper, 16'h0400);
    lim(2'h1, 16'h0100);
    `CHK(alarmLower, 16'h0000);
    lim(2'h2, 16'h0600);
    `CHK(critLimit, 16'h0600);
    wcfg(16'h0080);
    `CHK(cfgReadData, 16'h00C8);
    lim(2'h2, 16'h0700);
    `CHK(critLimit, 16'h0600);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    `CHK(cfgReadData, 16'h0000);
    done("locks");
    end_of_test();
  end
endmodule
